// [include/cmc_map.svh]
// Address fields, reset values and phase timing of core memory control
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH

// Clock period and the printed phase and access times
`define CMC_CLK_NS        4
`define CMC_T_PHASE_NS    450
`define CMC_T_RD_ACC_NS   400
`define CMC_T_WR_ACC_NS   200

// Longest times, so cycle counts round down
`define CMC_PHASE_CYC     (`CMC_T_PHASE_NS / `CMC_CLK_NS)
`define CMC_RD_ACC_CYC    (`CMC_T_RD_ACC_NS / `CMC_CLK_NS)
`define CMC_WR_ACC_CYC    (`CMC_T_WR_ACC_NS / `CMC_CLK_NS)
`define CMC_CNT_W         7

// Bus and storage geometry
`define CMC_ADDR_W        18
`define CMC_DATA_W        16
`define CMC_WORDS         8192
`define CMC_DEV_HI        17
`define CMC_DEV_LO        14
`define CMC_WORD_HI       13
`define CMC_WORD_LO       1
`define CMC_BYTE_BIT      0
`define CMC_ROW_HI        12
`define CMC_ROW_LO        6
`define CMC_COL_HI        5
`define CMC_COL_LO        0

// Jumper default for the device address
`define CMC_DEV_ADDR_RST  4'h0

`endif

// [include/cmc_pkg.sv]
// Types shared by the core memory cycle control
`include "cmc_map.svh"

package cmc_pkg;

    // Transaction kinds, ordered as the two control lines encode them
    typedef enum logic [1:0] {
        cmc_op_rd_restore,
        cmc_op_rd_pause,
        cmc_op_wr_word,
        cmc_op_wr_byte
    } cmc_op_e;

    // Cycle sequencer states
    typedef enum logic [1:0] {
        cmc_idle,
        cmc_read,
        cmc_write,
        cmc_done
    } cmc_state_e;

    // Inputs from the master on the shared bus
    typedef struct packed {
        logic [`CMC_ADDR_W-1:0] addr;
        logic [`CMC_DATA_W-1:0] data;
        logic [1:0]             ctl;
        logic                   msyn;
    } cmc_bus_s;

    // Drive and selection toward the stack
    typedef struct packed {
        logic                                 rd_en;
        logic                                 wr_en;
        logic [`CMC_DATA_W-1:0]               inhibit;
        logic [`CMC_ROW_HI-`CMC_ROW_LO:0]     row;
        logic [`CMC_COL_HI-`CMC_COL_LO:0]     col;
    } cmc_drv_s;

    // Whole register state of the controller
    typedef struct packed {
        cmc_bus_s               bus_s1;
        cmc_bus_s               bus_s2;
        logic                   dclo_s1;
        logic                   dclo_s2;
        cmc_state_e             st;
        cmc_op_e                op;
        logic [`CMC_CNT_W-1:0]  pcnt;
        logic [`CMC_CNT_W-1:0]  acnt;
        logic [`CMC_ADDR_W-1:0] addr_q;
        logic [`CMC_DATA_W-1:0] data_q;
        logic [`CMC_DATA_W-1:0] dreg;
        logic                   pause;
        logic                   ssyn;
        logic                   drive;
    } cmc_st_s;

endpackage

// [hdl/cmc_core.sv]
// Cycle control and storage of the 8K by 16 core memory
//
// Contract
// - Store 8192 sixteen bit words, one plane per bit
// - Serve four kinds: restore, pause, word, byte
// - Restoring read: read, present, then write back
// - Paused read returns word, skips restore phase
// - Paused read sets the pause flag
// - Other address: paused stays zero, target ORs
// - Word write clears by reading, then writes
// - Word write after pause skips the clearing read
// - Byte write keeps unselected byte, restores it
// - Byte write after pause skips clearing read too
// - Lowest address bit picks the written byte
// - Latch address, decode device and word
// - Power fail line inhibits every memory operation
// - Read drivers only in read, write in write
// - Direction names follow the master's viewpoint
// - Reset never clears or writes any location
// - Word splits into 128 rows, 64 columns
// - Top four address bits select this device
// - Word location from address bits 13 to 1
// - Inhibit zeros in write, uninhibited become one
`timescale 1ns/1ns
`include "cmc_map.svh"

module cmc_core #(
    parameter logic [3:0] dev_addr = `CMC_DEV_ADDR_RST
) (
    input  logic                     clk,
    input  logic                     rst_b,
    input  cmc_pkg::cmc_bus_s        bus_in,
    input  logic                     dc_lo,
    output logic                     ssyn,
    output logic [`CMC_DATA_W-1:0]   data_out,
    output logic                     data_oe_b,
    output logic                     pause_flag,
    output cmc_pkg::cmc_drv_s        drv
);
    import cmc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Constants and local signals

    localparam logic [`CMC_CNT_W-1:0] ph_last =
        `CMC_CNT_W'(`CMC_PHASE_CYC - 1);
    localparam logic [`CMC_CNT_W-1:0] rd_acc_m1 =
        `CMC_CNT_W'(`CMC_RD_ACC_CYC - 1);
    localparam logic [`CMC_CNT_W-1:0] wr_acc_m1 =
        `CMC_CNT_W'(`CMC_WR_ACC_CYC - 1);
    localparam int rd_ss = `CMC_RD_ACC_CYC + 1;
    localparam int wr_ss = `CMC_WR_ACC_CYC + 1;

    cmc_st_s                         st_ff;
    cmc_st_s                         nxt_st;
    cmc_op_e                         op_in;
    logic                            sel;
    logic                            start;
    logic                            is_wr;
    logic                            mem_clr;
    logic                            mem_set;
    logic [`CMC_WORD_HI-`CMC_WORD_LO:0] word;
    logic [`CMC_DATA_W-1:0]          mem_q;
    logic [`CMC_CNT_W-1:0]           acc_m1;

    // One plane per bit position, one core per word
    logic core_plane [`CMC_DATA_W][`CMC_WORDS];

    // Merge the bus byte into the kept word for byte writes
    function automatic logic [`CMC_DATA_W-1:0] cmc_merge(
        input cmc_op_e                op,
        input logic                   odd,
        input logic [`CMC_DATA_W-1:0] keep,
        input logic [`CMC_DATA_W-1:0] bus
    );
        logic [`CMC_DATA_W-1:0] w;
        w = bus;
        if (op == cmc_op_wr_byte) begin
            if (odd) begin
                w = {bus[15:8], keep[7:0]};
            end else begin
                w = {keep[15:8], bus[7:0]};
            end
        end
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Decode

    // Device match and word location from the synchronised address
    assign op_in  = cmc_op_e'(st_ff.bus_s2.ctl);
    assign sel    = st_ff.bus_s2.addr[`CMC_DEV_HI:`CMC_DEV_LO]
                    == dev_addr;
    // Accept only once the previous handshake has fully ended
    assign start  = (st_ff.st == cmc_idle) && st_ff.bus_s2.msyn
                    && !st_ff.dclo_s2 && sel && !st_ff.ssyn;
    assign is_wr  = (st_ff.op == cmc_op_wr_word)
                    || (st_ff.op == cmc_op_wr_byte);
    assign word   = st_ff.addr_q[`CMC_WORD_HI:`CMC_WORD_LO];
    assign acc_m1 = is_wr ? wr_acc_m1 : rd_acc_m1;

    ////////////////////////////////////////////////////////////////////
    // Stack drive

    // Strobe clears the location; power fail blocks both edges
    assign mem_clr = (st_ff.st == cmc_read) && (st_ff.pcnt == '0)
                     && !st_ff.dclo_s2;
    assign mem_set = (st_ff.st == cmc_write) && (st_ff.pcnt == ph_last)
                     && !st_ff.dclo_s2;

    // Polarity sets are enabled only in their own phase
    assign drv.rd_en   = (st_ff.st == cmc_read) && !st_ff.dclo_s2;
    assign drv.wr_en   = (st_ff.st == cmc_write) && !st_ff.dclo_s2;
    assign drv.inhibit = drv.wr_en ? ~st_ff.dreg : '0;
    assign drv.row     = word[`CMC_ROW_HI:`CMC_ROW_LO];
    assign drv.col     = word[`CMC_COL_HI:`CMC_COL_LO];

    // Sense every plane at the addressed core
    always_comb begin
        for (int b = 0; b < `CMC_DATA_W; b++) begin
            mem_q[b] = core_plane[b][word];
        end
    end

    // No reset here: contents must outlive power and reset
    always_ff @(posedge clk) begin
        for (int b = 0; b < `CMC_DATA_W; b++) begin
            if (mem_clr) begin
                core_plane[b][word] <= 1'b0;
            end else if (mem_set && !drv.inhibit[b]) begin
                core_plane[b][word] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer

    // Next state of the whole controller
    always_comb begin
        nxt_st         = st_ff;
        // Bus pins are asynchronous; two stages before use
        nxt_st.bus_s1  = bus_in;
        nxt_st.bus_s2  = st_ff.bus_s1;
        nxt_st.dclo_s1 = dc_lo;
        nxt_st.dclo_s2 = st_ff.dclo_s1;

        // Access counter raises slave sync at the access time
        if (st_ff.st != cmc_idle && !st_ff.ssyn) begin
            nxt_st.acnt = `CMC_CNT_W'(st_ff.acnt + 1'b1);
            if (st_ff.acnt == acc_m1) begin
                nxt_st.ssyn = 1'b1;
            end
        end

        case (st_ff.st)
            cmc_idle: begin
                if (start) begin
                    nxt_st.addr_q = st_ff.bus_s2.addr;
                    nxt_st.op     = op_in;
                    nxt_st.data_q = st_ff.bus_s2.data;
                    nxt_st.pcnt   = '0;
                    nxt_st.acnt   = '0;
                    if (st_ff.bus_s2.ctl[1] && st_ff.pause) begin
                        // Paused location already clear; go write
                        nxt_st.st   = cmc_write;
                        nxt_st.dreg = cmc_merge(op_in,
                            st_ff.bus_s2.addr[`CMC_BYTE_BIT],
                            st_ff.dreg, st_ff.bus_s2.data);
                    end else begin
                        nxt_st.st = cmc_read;
                    end
                end
            end
            cmc_read: begin
                nxt_st.pcnt = `CMC_CNT_W'(st_ff.pcnt + 1'b1);
                if (st_ff.pcnt == '0) begin
                    // Strobe: keep unselected byte, take bus byte
                    if (is_wr) begin
                        nxt_st.dreg = cmc_merge(st_ff.op,
                            st_ff.addr_q[`CMC_BYTE_BIT],
                            mem_q, st_ff.data_q);
                    end else begin
                        nxt_st.dreg  = mem_q;
                        nxt_st.drive = 1'b1;
                    end
                end
                if (st_ff.pcnt == ph_last) begin
                    nxt_st.pcnt = '0;
                    if (st_ff.op == cmc_op_rd_pause) begin
                        // Restore suppressed; location left clear
                        nxt_st.st    = cmc_done;
                        nxt_st.pause = 1'b1;
                    end else begin
                        nxt_st.st    = cmc_write;
                        nxt_st.pause = 1'b0;
                    end
                end
            end
            cmc_write: begin
                nxt_st.pcnt = `CMC_CNT_W'(st_ff.pcnt + 1'b1);
                if (st_ff.pcnt == ph_last) begin
                    nxt_st.st    = cmc_done;
                    nxt_st.pause = 1'b0;
                end
            end
            cmc_done: begin
                // Hold slave sync until the master lets go
                nxt_st.ssyn = 1'b1;
                if (!st_ff.bus_s2.msyn) begin
                    nxt_st.ssyn  = 1'b0;
                    nxt_st.drive = 1'b0;
                    nxt_st.st    = cmc_idle;
                end
            end
            default: begin
                nxt_st.st = cmc_idle;
            end
        endcase

        // Power fail aborts; the master then sees no slave sync
        if (st_ff.dclo_s2 && st_ff.st != cmc_idle) begin
            nxt_st.st    = cmc_idle;
            nxt_st.ssyn  = 1'b0;
            nxt_st.drive = 1'b0;
            nxt_st.pcnt  = '0;
        end
    end

    // State register; reset leaves the stack untouched
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Bus side outputs, all from flip-flops
    assign ssyn       = st_ff.ssyn;
    assign data_out   = st_ff.dreg;
    assign data_oe_b  = !st_ff.drive;
    assign pause_flag = st_ff.pause;

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cmc_cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_rd_start;
        start && !op_in[1];
    endsequence

    sequence s_skip_start;
        start && op_in[1] && st_ff.pause;
    endsequence

    property p_rd_acc;
        disable iff (!rst_b || st_ff.dclo_s2)
        s_rd_start |-> ##rd_ss (st_ff.ssyn && !$past(st_ff.ssyn));
    endproperty
    a_rd_acc: assert property (p_rd_acc)
        else $error("read slave sync not at access time");

    property p_wr_acc;
        disable iff (!rst_b || st_ff.dclo_s2)
        start && op_in[1] |-> ##wr_ss (st_ff.ssyn && !$past(st_ff.ssyn));
    endproperty
    a_wr_acc: assert property (p_wr_acc)
        else $error("write slave sync not at access time");

    property p_skip;
        disable iff (!rst_b || st_ff.dclo_s2)
        s_skip_start |=> st_ff.st == cmc_write ##1 st_ff.st == cmc_write;
    endproperty
    a_skip: assert property (p_skip)
        else $error("write after pause did not skip read");

    property p_pause_set;
        disable iff (!rst_b || st_ff.dclo_s2)
        st_ff.st == cmc_read && st_ff.op == cmc_op_rd_pause
            && st_ff.pcnt == ph_last |=> st_ff.pause && !drv.wr_en;
    endproperty
    a_pause_set: assert property (p_pause_set)
        else $error("paused read left no pause flag");

    property p_pause_clr;
        mem_set |=> !st_ff.pause;
    endproperty
    a_pause_clr: assert property (p_pause_clr)
        else $error("pause flag stale after write");

    property p_drv;
        drv.rd_en |-> st_ff.st == cmc_read && !drv.wr_en
            && drv.inhibit == '0;
    endproperty
    a_drv: assert property (p_drv)
        else $error("read and write drive overlap");

    property p_stored;
        disable iff (!rst_b || st_ff.dclo_s2)
        mem_set |=> (mem_q & st_ff.dreg) == st_ff.dreg;
    endproperty
    a_stored: assert property (p_stored)
        else $error("uninhibited bit not set by write");

    property p_dclo;
        st_ff.dclo_s2 |-> !mem_clr && !mem_set ##1 st_ff.st == cmc_idle;
    endproperty
    a_dclo: assert property (p_dclo)
        else $error("memory active during power fail");

    // Either half: bus byte where A0 points, sensed byte in the other
    property p_byte;
        disable iff (!rst_b || st_ff.dclo_s2)
        mem_clr && st_ff.op == cmc_op_wr_byte
            |=> st_ff.dreg == ($past(st_ff.addr_q[0])
                ? {$past(st_ff.data_q[15:8]), $past(mem_q[7:0])}
                : {$past(mem_q[15:8]), $past(st_ff.data_q[7:0])});
    endproperty
    a_byte: assert property (p_byte)
        else $error("byte merge kept the wrong byte");

    property p_hold;
        disable iff (!rst_b || st_ff.dclo_s2)
        st_ff.ssyn && st_ff.bus_s2.msyn |=> st_ff.ssyn;
    endproperty
    a_hold: assert property (p_hold)
        else $error("slave sync dropped before master sync");

endmodule

// [testbench/cmc_master_model.sv]
// Bus master model that runs one handshake transfer at a time
`timescale 1ns/1ns
`include "cmc_map.svh"

module cmc_master_model
    import cmc_pkg::*;
(
    input  logic                   clk,
    input  logic                   ssyn,
    input  logic [`CMC_DATA_W-1:0] data_out,
    input  logic                   data_oe_b,
    output cmc_pkg::cmc_bus_s      bus
);
    logic [`CMC_DATA_W-1:0] rdata;
    logic                   got;
    logic                   oe_b;
    int                     lat;

    initial begin
        bus = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One transfer: qualifiers settle a cycle before the strobe
    task automatic xfer(input logic [`CMC_ADDR_W-1:0] a,
                        input logic [`CMC_DATA_W-1:0] d,
                        input cmc_op_e k);
        int n;
        n = 0;
        @(negedge clk);
        bus.addr <= a;
        bus.data <= d;
        bus.ctl  <= k;
        @(negedge clk);
        bus.msyn <= 1'b1;
        got = 1'b0;
        // Bounded wait, a refused request never answers
        while (n < 160 && got !== 1'b1) begin
            @(posedge clk);
            got = (ssyn === 1'b1);
            n++;
        end
        lat = n;
        rdata = data_out; // Data in flows toward the master
        oe_b = data_oe_b;
        @(negedge clk);
        bus.msyn <= 1'b0;
        n = 0;
        // Slave sync must drop before the next request
        while (n < 20 && ssyn !== 1'b0) begin
            @(posedge clk);
            n++;
        end
        // Released lines show no stale value
        @(negedge clk);
        bus.addr <= ~a;
        bus.data <= ~d;
    endtask
endmodule

// [testbench/core_memory_cycle_control_test.sv]
// Self-checking bench for the core memory cycle control
`timescale 1ns/1ns
`include "cmc_map.svh"

module core_memory_cycle_control_test;
    import cmc_pkg::*;

    logic                   clk;
    logic                   rst_b;
    logic                   dc_lo;
    cmc_bus_s               bus;
    logic                   ssyn;
    logic [`CMC_DATA_W-1:0] data_out;
    logic                   data_oe_b;
    logic                   pause_flag;
    cmc_drv_s               drv;
    int                     fail_count;
    int                     comparisons;
    int                     cycles;
    int                     rd_cnt;
    int                     wr_cnt;
    int                     both_cnt;
    logic [6:0]             row_seen;
    logic [5:0]             col_seen;
    logic [`CMC_DATA_W-1:0] inh_seen;
    logic [`CMC_ADDR_W-1:0] a1;
    logic [`CMC_ADDR_W-1:0] a2;

    cmc_core #(.dev_addr(4'h5)) i_cmc_core (
        .clk        (clk),
        .rst_b      (rst_b),
        .bus_in     (bus),
        .dc_lo      (dc_lo),
        .ssyn       (ssyn),
        .data_out   (data_out),
        .data_oe_b  (data_oe_b),
        .pause_flag (pause_flag),
        .drv        (drv)
    );

    cmc_master_model i_cmc_master_model (
        .clk       (clk),
        .ssyn      (ssyn),
        .data_out  (data_out),
        .data_oe_b (data_oe_b),
        .bus       (bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // 250 MHz clock and a hang ceiling well above the whole run
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    // Drive activity seen at the settled falling edge
    always @(negedge clk) begin
        if (drv.rd_en === 1'b1) begin
            rd_cnt++;
            row_seen = drv.row;
            col_seen = drv.col;
        end
        if (drv.wr_en === 1'b1) begin
            wr_cnt++;
            inh_seen = drv.inhibit;
        end
        if (drv.rd_en === 1'b1 && drv.wr_en === 1'b1) both_cnt++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One transfer, then the whole 224 cycle stack sequence, then counts
    task automatic op(input logic [`CMC_ADDR_W-1:0] a,
                      input logic [`CMC_DATA_W-1:0] d,
                      input cmc_op_e k, input int er, input int ew);
        @(posedge clk);
        rd_cnt = 0;
        wr_cnt = 0;
        both_cnt = 0;
        i_cmc_master_model.xfer(a, d, k);
        repeat (240) @(negedge clk);
        check(rd_cnt, er);
        check(wr_cnt, ew);
        check(both_cnt, 0);
    endtask

    task automatic rd(input logic [`CMC_ADDR_W-1:0] a,
                      input logic [`CMC_DATA_W-1:0] e);
        op(a, 16'h0000, cmc_op_rd_restore, 112, 112);
        check(i_cmc_master_model.rdata, e);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Word write, then two restoring reads of the same word
    task automatic s_word;
        op(a1, 16'h1234, cmc_op_wr_word, 112, 112);
        check(inh_seen, 16'hedcb);
        check(i_cmc_master_model.lat inside {[50:56]}, 1);
        check(i_cmc_master_model.oe_b, 1'b1);
        rd(a1, 16'h1234);
        check(i_cmc_master_model.lat inside {[100:106]}, 1);
        check(i_cmc_master_model.oe_b, 1'b0);
        check(row_seen, a1[13:7]);
        check(col_seen, a1[6:1]);
        rd(a1, 16'h1234);
    endtask

    // Paused read, then a short word write to the same place
    task automatic s_pause;
        op(a1, 16'h0000, cmc_op_rd_pause, 112, 0);
        check(i_cmc_master_model.rdata, 16'h1234);
        check(pause_flag, 1'b1);
        op(a1, 16'hbeef, cmc_op_wr_word, 0, 112);
        check(pause_flag, 1'b0);
        rd(a1, 16'hbeef);
    endtask

    // Byte writes: high byte after a clear, low byte after a pause
    task automatic s_byte;
        op(a1 | 18'h00001, 16'h7700, cmc_op_wr_byte, 112, 112);
        rd(a1, 16'h77ef);
        op(a1, 16'h0000, cmc_op_rd_pause, 112, 0);
        op(a1, 16'haa11, cmc_op_wr_byte, 0, 112);
        rd(a1, 16'h7711);
    endtask

    // Write after a pause aimed elsewhere ORs there and leaves zero here
    task automatic s_other;
        op(a2, 16'h00f0, cmc_op_wr_word, 112, 112);
        op(a1, 16'h0000, cmc_op_rd_pause, 112, 0);
        op(a2, 16'h0f00, cmc_op_wr_word, 0, 112);
        rd(a2, 16'h0ff0);
        rd(a1, 16'h0000);
        check(pause_flag, 1'b0);
    endtask

    // Foreign device address and power fail both get no answer
    task automatic s_refuse;
        op({4'h3, a2[13:0]}, 16'h0000, cmc_op_wr_word, 0, 0);
        check(i_cmc_master_model.got, 1'b0);
        dc_lo <= 1'b1;
        op(a2, 16'hffff, cmc_op_wr_word, 0, 0);
        check(i_cmc_master_model.got, 1'b0);
        @(negedge clk);
        dc_lo <= 1'b0;
        rd(a2, 16'h0ff0);
    endtask

    // Reset in mid-run leaves the stored words alone
    task automatic s_reset;
        @(negedge clk);
        rst_b <= 1'b0;
        repeat (3) @(negedge clk);
        check({ssyn, data_oe_b, pause_flag}, 3'b010);
        check({drv.rd_en, drv.wr_en}, 2'b00);
        rst_b <= 1'b1;
        rd(a2, 16'h0ff0);
        rd(a1, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_b = 1'b0;
        dc_lo = 1'b0;
        fail_count = 0;
        comparisons = 0;
        cycles = 0;
        a1 = {4'h5, 13'h0a5b, 1'b0};
        a2 = {4'h5, 13'h1f80, 1'b0};
        repeat (12) @(negedge clk);
        rst_b <= 1'b1;
        s_word();
        s_pause();
        s_byte();
        s_other();
        s_refuse();
        s_reset();
        end_sim();
    end
endmodule
